// *** verilog/mrr_top.sv ***
/*
   Address decoder, low-memory remap, on-chip SRAM and reset cause logic.
   Assumes the core issues one-cycle requests and waits for ack or abort;
   flash and other registers answer on the ext_ port; rst_n is power-on.
*/
// Contract
// - accesses outside every defined region are refused with a data abort
// - multi-byte data is little endian, low byte at lowest address
// - a 4 kB register area is decoded near the top of the map
// - SRAM is 1536 words of 32 bits at 0x40000, code or data
// - SRAM takes 8, 16 and 32-bit accesses, writing only addressed bytes
// - lowest 94 kB alias flash, or SRAM in its lowest 6 kB only, as the remap bit selects
// - every reset maps flash back to address zero
// - remap bit 0 at 0xFFFF0220 selects SRAM when set, flash when clear
// - remap register is loaded with zero by every reset, before boot firmware runs
// - every reset runs boot firmware first, then the zero vector
// - boot firmware memory is hidden from user code
// - status bit 3 set by external reset pin
// - status bit 1 set by watchdog timeout reset
// - status bit 0 set by power-on reset
// - writing 1 to status bit 2 starts a software reset, bit stays set
// - status bits 7 to 4 read zero
// - clear register at 0xFFFF0234 clears status bits written as 1
// - clear write leaving soft bit set starts another software reset
// - internal resets spare status; only power-on resets watchdog; SRAM survives
module mrr_top (
   // clock, reset, enable
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   input  wire logic                       clk_en,
   // core load/store bus
   input  wire logic                       bus_req,
   input  wire logic                       bus_we,
   input  wire logic [1:0]                 bus_size,
   input  wire logic [mrr_pkg::ADDR_W-1:0] bus_addr,
   input  wire logic [mrr_pkg::DATA_W-1:0] bus_wdata,
   output logic                            bus_ack_q,
   output logic                            bus_abort_q,
   output logic [mrr_pkg::DATA_W-1:0]      bus_rdata_q,
   // flash and peripheral register path
   output logic                            ext_req_q,
   output logic                            ext_mmr_q,
   output logic                            ext_we_q,
   output logic [mrr_pkg::ADDR_W-1:0]      ext_addr_q,
   output logic [3:0]                      ext_be_q,
   output logic [mrr_pkg::DATA_W-1:0]      ext_wdata_q,
   input  wire logic                       ext_ack,
   input  wire logic [mrr_pkg::DATA_W-1:0] ext_rdata,
   // reset sources and results
   input  wire logic                       ext_rst_pin_n,
   input  wire logic                       wdog_expire,
   input  wire logic                       boot_done,
   output logic                            sys_reset_q,
   output logic                            boot_mode_q,
   output logic                            remap_sram_q
);
   import mrr_pkg::*;
   mrr_state_e                state_q, state_d;
   logic [3:0]                status_q, status_d;
   logic [3:0]                cnt_q, cnt_d;
   logic [1:0]                ext_size_q, ext_size_d;
   logic                      remap_d, boot_d, sysrst_d;
   logic                      ack_d, abort_d, ext_req_d, ext_mmr_d, ext_we_d;
   logic [31:0]               rdata_d, ext_addr_d, ext_wdata_d;
   logic [3:0]                ext_be_d;
   logic                      ext_s1_q, ext_s2_q;
   logic [31:0]               phys, wlane, sram_off, sram_word;
   logic [SRAM_IDX_W-1:0]     sram_idx;
   logic                      in_alias, hit_sram, hit_kernel, hit_flash, hit_mmr;
   logic                      hit_remap, hit_status, hit_clear, misalign, dec_abort;
   logic [1:0]                lane;
   logic [3:0]                be;
   logic                      hw_evt, taken, sw_evt, sram_we, wr_remap_val;
   // read data is shifted down to bit 0 and zero filled above the size
   function automatic logic [31:0] align_rd(logic [31:0] w, logic [1:0] ln,
                                            logic [1:0] sz);
      logic [31:0] s;
      s = w >> {ln, 3'b000};
      if (sz == SZ_BYTE) begin
         return {24'h00_0000, s[7:0]};
      end else if (sz == SZ_HALF) begin
         return {16'h0000, s[15:0]};
      end
      return s;
   endfunction
   // reset pin comes from outside: two flops before anything looks at it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ext_s1_q <= 1'b1;
         ext_s2_q <= 1'b1;
      end else if (clk_en) begin
         ext_s1_q <= ext_rst_pin_n;
         ext_s2_q <= ext_s1_q;
      end
   end
   // address decode; uses the registered remap bit so no access sees a mix
   always_comb begin
      in_alias = bus_addr <= ALIAS_LAST;
      if (!in_alias) begin
         phys = bus_addr;
      end else if (remap_sram_q) begin
         phys = SRAM_BASE + bus_addr;
      end else begin
         phys = FLASH_BASE + bus_addr;
      end
      hit_sram   = phys >= SRAM_BASE && phys <= SRAM_LAST;
      hit_kernel = phys >= KERNEL_BASE && phys <= FLASH_LAST;
      hit_flash  = phys >= FLASH_BASE && phys <= FLASH_LAST
                   && (!hit_kernel || boot_mode_q);
      hit_mmr    = phys >= MMR_BASE && phys <= MMR_LAST;
      hit_remap  = phys == REMAP_ADDR;
      hit_status = phys == STATUS_ADDR;
      hit_clear  = phys == CLEAR_ADDR;
      lane       = bus_addr[1:0];
      // byte enables follow size and lane
      if (bus_size == SZ_BYTE) begin
         be       = 4'h1 << lane;
         misalign = 1'b0;
      end else if (bus_size == SZ_HALF) begin
         be       = 4'h3 << lane;
         misalign = lane[0];
      end else if (bus_size == SZ_WORD) begin
         be       = 4'hf;
         misalign = |lane;
      end else begin
         be       = 4'h0;
         misalign = 1'b1;
      end
      dec_abort = misalign || !(hit_sram || hit_flash || hit_mmr);
      wlane     = bus_wdata << {lane, 3'b000};
      sram_off  = phys - SRAM_BASE;
      sram_idx  = sram_off[SRAM_IDX_W+1:2];
   end
   // request and reset event qualification
   assign hw_evt       = !ext_s2_q || wdog_expire;
   assign taken        = clk_en && bus_req && state_q == ST_IDLE && !hw_evt;
   assign wr_remap_val = bus_wdata[REMAP_BIT];
   assign sw_evt       = taken && bus_we && !dec_abort
                         && ((hit_status && bus_wdata[SOFT_BIT])
                         || (hit_clear && status_q[SOFT_BIT]
                             && !bus_wdata[SOFT_BIT]));
   // sram: one byte-wide array per lane, no reset so contents survive
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         logic [7:0] mem_q [SRAM_WORDS];
         always_ff @(posedge clock) begin
            if (clk_en && sram_we && be[b]) begin
               mem_q[sram_idx] <= wlane[b*8 +: 8];
            end
         end
         assign sram_word[b*8 +: 8] = mem_q[sram_idx];
      end
   endgenerate
   // next state of bus answer, registers and reset sequencing
   always_comb begin
      state_d     = state_q;
      status_d    = status_q;
      cnt_d       = cnt_q;
      remap_d     = remap_sram_q;
      boot_d      = boot_mode_q;
      sysrst_d    = sys_reset_q;
      ack_d       = 1'b0;
      abort_d     = 1'b0;
      rdata_d     = bus_rdata_q;
      ext_req_d   = 1'b0;
      ext_mmr_d   = ext_mmr_q;
      ext_we_d    = ext_we_q;
      ext_addr_d  = ext_addr_q;
      ext_be_d    = ext_be_q;
      ext_wdata_d = ext_wdata_q;
      ext_size_d  = ext_size_q;
      sram_we     = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (taken) begin
               if (dec_abort) begin
                  abort_d = 1'b1;
               end else if (hit_sram) begin
                  ack_d   = 1'b1;
                  sram_we = bus_we;
                  rdata_d = align_rd(sram_word, lane, bus_size);
               end else if (hit_remap) begin
                  ack_d   = 1'b1;
                  rdata_d = '0;
                  rdata_d[REMAP_BIT] = remap_sram_q;
                  // upper bits are reserved and not stored
                  if (bus_we) begin
                     remap_d = wr_remap_val;
                  end
               end else if (hit_status) begin
                  ack_d   = 1'b1;
                  rdata_d = {28'h000_0000, status_q};
                  if (bus_we && bus_wdata[SOFT_BIT]) begin
                     status_d[SOFT_BIT] = 1'b1;
                  end
               end else if (hit_clear) begin
                  ack_d   = 1'b1;
                  rdata_d = '0; // write only
                  if (bus_we) begin
                     status_d = status_q & ~bus_wdata[3:0];
                  end
               end else begin
                  // flash or another register: hand over and wait
                  ext_req_d   = 1'b1;
                  ext_mmr_d   = hit_mmr;
                  ext_we_d    = bus_we;
                  ext_addr_d  = phys;
                  ext_be_d    = be;
                  ext_wdata_d = wlane;
                  ext_size_d  = bus_size;
                  state_d     = ST_EXT;
               end
            end
         end
         ST_EXT: begin
            if (ext_ack) begin
               ack_d   = 1'b1;
               rdata_d = align_rd(ext_rdata, ext_addr_q[1:0], ext_size_q);
               state_d = ST_IDLE;
            end
         end
         ST_RESET: begin
            if (cnt_q == 4'h0) begin
               state_d  = ST_IDLE;
               sysrst_d = 1'b0;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (boot_done && state_q != ST_RESET) begin
         boot_d = 1'b0; // firmware has jumped to the zero vector
      end
      // reset events come last so a set beats a clear in the same cycle
      if (hw_evt || sw_evt) begin
         state_d  = ST_RESET;
         cnt_d    = RST_HOLD;
         sysrst_d = 1'b1; // watchdog is not on this reset
         remap_d  = 1'b0;
         boot_d   = 1'b1;
         if (!ext_s2_q) begin
            status_d[EXT_BIT] = 1'b1;
         end
         if (wdog_expire) begin
            status_d[WDOG_BIT] = 1'b1;
         end
         if (sw_evt) begin
            status_d[SOFT_BIT] = 1'b1;
         end
      end
   end
   // all control state; status keeps its bits across internal resets
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q      <= ST_IDLE;
         status_q     <= STATUS_POR;
         cnt_q        <= 4'h0;
         remap_sram_q <= 1'b0;
         boot_mode_q  <= 1'b1;
         sys_reset_q  <= 1'b0;
         bus_ack_q    <= 1'b0;
         bus_abort_q  <= 1'b0;
         bus_rdata_q  <= '0;
         ext_req_q    <= 1'b0;
         ext_mmr_q    <= 1'b0;
         ext_we_q     <= 1'b0;
         ext_addr_q   <= '0;
         ext_be_q     <= 4'h0;
         ext_wdata_q  <= '0;
         ext_size_q   <= SZ_BYTE;
      end else if (clk_en) begin
         state_q      <= state_d;
         status_q     <= status_d;
         cnt_q        <= cnt_d;
         remap_sram_q <= remap_d;
         boot_mode_q  <= boot_d;
         sys_reset_q  <= sysrst_d;
         bus_ack_q    <= ack_d;
         bus_abort_q  <= abort_d;
         bus_rdata_q  <= rdata_d;
         ext_req_q    <= ext_req_d;
         ext_mmr_q    <= ext_mmr_d;
         ext_we_q     <= ext_we_d;
         ext_addr_q   <= ext_addr_d;
         ext_be_q     <= ext_be_d;
         ext_wdata_q  <= ext_wdata_d;
         ext_size_q   <= ext_size_d;
      end
   end
   // checks on the block's outputs and internal state
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_unmapped_abort: assert property (
      taken && dec_abort |=> bus_abort_q && !bus_ack_q)
      else $error("unmapped or misaligned access not aborted");
   a_kernel_hidden: assert property (
      taken && hit_kernel && !boot_mode_q |=> bus_abort_q)
      else $error("boot firmware area reachable by user code");
   a_reset_remap: assert property (
      $rose(sys_reset_q) |-> !remap_sram_q && boot_mode_q)
      else $error("reset left sram at zero or skipped boot");
   a_remap_write: assert property (
      taken && bus_we && hit_remap && !dec_abort
      |=> bus_ack_q && remap_sram_q == $past(wr_remap_val))
      else $error("remap bit did not follow write");
   a_sram_alias: assert property (
      taken && remap_sram_q && bus_addr == 32'h0 && bus_size == SZ_WORD
      |=> bus_ack_q && bus_rdata_q == $past(sram_word))
      else $error("alias did not return sram word zero");
   a_soft_reset: assert property (
      taken && bus_we && hit_status && bus_wdata[SOFT_BIT] && !dec_abort
      |=> sys_reset_q && status_q[SOFT_BIT])
      else $error("software reset not started");
   a_clear_retrig: assert property (
      taken && bus_we && hit_clear && status_q[SOFT_BIT] && !bus_wdata[SOFT_BIT] && !dec_abort
      |=> sys_reset_q && state_q == ST_RESET)
      else $error("clear write did not retrigger software reset");
   a_clear_bits: assert property (
      taken && bus_we && hit_clear && bus_wdata[POR_BIT] && !dec_abort |=> !status_q[POR_BIT])
      else $error("clear write did not clear power-on flag");
   a_pin_flag: assert property (
      clk_en && !ext_s2_q |=> status_q[EXT_BIT] && sys_reset_q)
      else $error("external reset not recorded");
   a_wdog_flag: assert property (
      clk_en && wdog_expire |=> status_q[WDOG_BIT] && sys_reset_q)
      else $error("watchdog reset not recorded");
   a_status_top: assert property (
      taken && !bus_we && hit_status && !dec_abort |=> bus_rdata_q[31:4] == '0)
      else $error("status upper bits not zero");
   c_soft_reset: cover property (sw_evt ##1 sys_reset_q);
   c_remap_sram: cover property (taken && in_alias && remap_sram_q && hit_sram);
   c_ext_done: cover property (ext_req_q ##[1:20] bus_ack_q);
endmodule

// *** verilog/mrr_pkg.sv ***
/*
   Constants for the memory remap, address decode and reset cause block.
   Assumes a 32-bit core bus with byte addressing and a 10 MHz core clock.
*/
package mrr_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;

   // address map
   localparam logic [31:0] ALIAS_LAST  = 32'h0001_77ff; // 94 kB alias window
   localparam logic [31:0] SRAM_BASE   = 32'h0004_0000;
   localparam logic [31:0] SRAM_LAST   = 32'h0004_17ff;
   localparam int          SRAM_WORDS  = 1536;
   localparam int          SRAM_IDX_W  = 11;
   localparam logic [31:0] FLASH_BASE  = 32'h0008_0000;
   localparam logic [31:0] KERNEL_BASE = 32'h0009_7800; // boot firmware, hidden
   localparam logic [31:0] FLASH_LAST  = 32'h0009_7fff;
   localparam logic [31:0] MMR_BASE    = 32'hffff_0000; // 4 kB register area
   localparam logic [31:0] MMR_LAST    = 32'hffff_0fff;

   // own registers
   localparam logic [31:0] REMAP_ADDR  = 32'hffff_0220;
   localparam logic [31:0] STATUS_ADDR = 32'hffff_0230;
   localparam logic [31:0] CLEAR_ADDR  = 32'hffff_0234;

   // field positions
   localparam int REMAP_BIT = 0;
   localparam int POR_BIT   = 0;
   localparam int WDOG_BIT  = 1;
   localparam int SOFT_BIT  = 2;
   localparam int EXT_BIT   = 3;
   localparam logic [3:0] STATUS_POR = 4'h1;

   // reset pulse length toward the rest of the chip
   localparam int CLK_PERIOD_NS = 100;
   localparam int RST_HOLD_NS   = 500;
   localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RST_HOLD = 4'(RST_HOLD_CYC);

   // access sizes on the core bus
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_EXT   = 2'b01,
      ST_RESET = 2'b10
   } mrr_state_e;
endpackage

// *** verif/mrr_ext_model.sv ***
/*
   Flash and peripheral register responder on the ext_ path of mrr_top.
   Assumes one outstanding request; answers delay plus one cycles after it sees the request.
*/
module mrr_ext_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // request side
   input  wire logic        ext_req_q,
   input  wire logic [31:0] ext_addr_q,
   input  wire logic [3:0]  delay,
   // answer side
   output logic             ext_ack,
   output logic [31:0]      ext_rdata
);
   logic        busy;
   logic [3:0]  cnt;
   logic [31:0] addr;

   // answer one word per request; data wobbles between answers so stale reads show
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy      <= 1'b0;
         cnt       <= 4'h0;
         addr      <= 32'h0;
         ext_ack   <= 1'b0;
         ext_rdata <= 32'h0;
      end else begin
         ext_ack   <= 1'b0;
         ext_rdata <= ~ext_rdata;
         if (ext_req_q) begin
            busy <= 1'b1;
            cnt  <= delay;
            addr <= ext_addr_q;
         end else if (busy && cnt == 4'h0) begin
            ext_ack   <= 1'b1;
            ext_rdata <= {addr[15:2], 2'h0, ~addr[15:2], 2'h3}; // lane order
            busy      <= 1'b0;
         end else if (busy) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule

// *** verif/mrr_top_tb_top.sv ***
/*
   Self-checking bench for mrr_top: drives the core bus, notes expected answers.
   Assumes the ext responder model stands on the flash and register path.
*/
module mrr_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import mrr_pkg::*;
   typedef struct {logic abort; logic chk; logic [31:0] data;} mrr_note_s;
   logic clock = 0, rst_n = 0, clk_en = 1, bus_req = 0, bus_we = 0;
   logic [1:0] bus_size = 0;
   logic [31:0] bus_addr = 0, bus_wdata = 0, bus_rdata_q, ext_addr_q, ext_wdata_q, ext_rdata;
   logic bus_ack_q, bus_abort_q, ext_req_q, ext_mmr_q, ext_we_q, ext_ack;
   logic [3:0] ext_be_q, delay = 0;
   logic ext_rst_pin_n = 1, wdog_expire = 0, boot_done = 0;
   logic sys_reset_q, boot_mode_q, remap_sram_q;
   mrr_note_s notes[$];
   mrr_note_s nt;
   int n_mismatch = 0, compares = 0, seed = 926, k;
   logic [31:0] a, d;
   logic [31:0] bad_list[4] = '{32'h0004_1800, 32'h0001_7800, 32'h0009_8000, 32'hfffe_fffc};

   always #50 clock = ~clock;

   mrr_top mrr_top_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req),
      .bus_we(bus_we), .bus_size(bus_size), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_ack_q(bus_ack_q), .bus_abort_q(bus_abort_q), .bus_rdata_q(bus_rdata_q),
      .ext_req_q(ext_req_q), .ext_mmr_q(ext_mmr_q), .ext_we_q(ext_we_q),
      .ext_addr_q(ext_addr_q), .ext_be_q(ext_be_q), .ext_wdata_q(ext_wdata_q),
      .ext_ack(ext_ack), .ext_rdata(ext_rdata), .ext_rst_pin_n(ext_rst_pin_n),
      .wdog_expire(wdog_expire), .boot_done(boot_done), .sys_reset_q(sys_reset_q),
      .boot_mode_q(boot_mode_q), .remap_sram_q(remap_sram_q));
   mrr_ext_model mrr_ext_model_i (.clock(clock), .rst_n(rst_n), .ext_req_q(ext_req_q),
      .ext_addr_q(ext_addr_q), .delay(delay), .ext_ack(ext_ack), .ext_rdata(ext_rdata));

   function automatic logic [31:0] pat(input logic [31:0] x);
      return {x[15:2], 2'h0, ~x[15:2], 2'h3};
   endfunction

   task automatic print_verdict();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cmp_bit(input string what, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %b seen %b", what, e, g);
      end
   endtask

   // one-cycle request, then a bounded wait for ack or abort
   task automatic access(input logic we, input logic [1:0] sz, input logic [31:0] ad,
                         input logic [31:0] wd, input logic ab, input logic [31:0] e);
      int i;
      notes.push_back('{ab, !we, e});
      @(posedge clock);
      bus_req   <= 1'b1;
      bus_we    <= we;
      bus_size  <= sz;
      bus_addr  <= ad;
      bus_wdata <= wd;
      @(posedge clock);
      bus_req <= 1'b0;
      for (i = 0; i < 50; i++) begin
         @(negedge clock);
         if (bus_ack_q === 1'b1 || bus_abort_q === 1'b1) break;
      end
      if (i == 50) begin
         n_mismatch++;
         $display("mismatch answer expected ack seen none");
         print_verdict();
      end
   endtask

   task automatic rd(input logic [1:0] sz, input logic [31:0] ad, input logic [31:0] e);
      access(1'b0, sz, ad, 32'h0, 1'b0, e);
   endtask

   task automatic wr(input logic [1:0] sz, input logic [31:0] ad, input logic [31:0] wd);
      access(1'b1, sz, ad, wd, 1'b0, 32'h0);
   endtask

   // chip reset pulse must end within a bounded time
   task automatic rst_wait();
      int i;
      for (i = 0; i < 100 && sys_reset_q !== 1'b0; i++) @(negedge clock);
      if (i == 100) begin
         n_mismatch++;
         $display("mismatch sys_reset expected 0 seen 1");
         print_verdict();
      end
   endtask

   // answer watcher: oldest note against what came back
   always @(negedge clock) begin
      if (rst_n && (bus_ack_q === 1'b1 || bus_abort_q === 1'b1)) begin
         if (notes.size() == 0) begin
            n_mismatch++;
            $display("mismatch answer expected none seen one");
         end else begin
            nt = notes.pop_front();
            cmp_bit("abort", nt.abort, bus_abort_q);
            if (nt.chk && !nt.abort) cmp_word("rdata", nt.data, bus_rdata_q);
         end
      end
   end

   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      cmp_bit("boot_mode", 1'b1, boot_mode_q);
      cmp_bit("remap", 1'b0, remap_sram_q);
      rd(SZ_WORD, STATUS_ADDR, 32'h1);
      rd(SZ_WORD, KERNEL_BASE, pat(KERNEL_BASE));
      @(posedge clock) boot_done <= 1'b1;
      @(posedge clock) boot_done <= 1'b0;
      access(1'b0, SZ_WORD, KERNEL_BASE, 32'h0, 1'b1, 32'h0);
      foreach (bad_list[i]) access(1'b1, SZ_WORD, bad_list[i], 32'h0, 1'b1, 32'h0);
      delay <= 4'h4;
      rd(SZ_WORD, 32'hffff_0ffc, pat(32'hffff_0ffc));
      cmp_bit("ext_mmr", 1'b1, ext_mmr_q);
      // a half write handed out must carry lane position and byte enables
      wr(SZ_HALF, 32'hffff_0ff2, 32'h0000_1234);
      cmp_bit("ext_we", 1'b1, ext_we_q);
      cmp_word("ext_be", 32'h0000_000c, {28'h000_0000, ext_be_q});
      cmp_word("ext_wdata", 32'h1234_0000, ext_wdata_q);
      // lane tests: later narrow writes must leave the other bytes alone
      wr(SZ_WORD, SRAM_BASE, 32'h4433_2211);
      wr(SZ_BYTE, SRAM_BASE + 32'h1, 32'h0000_00aa);
      wr(SZ_HALF, SRAM_BASE + 32'h2, 32'h0000_ccbb);
      rd(SZ_WORD, SRAM_BASE, 32'hccbb_aa11);
      rd(SZ_BYTE, SRAM_BASE + 32'h3, 32'h0000_00cc);
      rd(SZ_HALF, SRAM_BASE, 32'h0000_aa11);
      // illegal size and misaligned word are refused; the word must stay intact
      access(1'b0, 2'h3, SRAM_BASE, 32'h0, 1'b1, 32'h0);
      access(1'b1, SZ_WORD, SRAM_BASE + 32'h2, 32'hffff_ffff, 1'b1, 32'h0);
      wr(SZ_WORD, SRAM_LAST - 32'h3, 32'h1234_5678);
      rd(SZ_WORD, SRAM_LAST - 32'h3, 32'h1234_5678);
      delay <= 4'h0;
      rd(SZ_WORD, 32'h10, pat(FLASH_BASE + 32'h10));
      cmp_word("ext_addr", FLASH_BASE + 32'h10, ext_addr_q);
      rd(SZ_BYTE, ALIAS_LAST, pat(FLASH_BASE + ALIAS_LAST) >> 24);
      wr(SZ_WORD, REMAP_ADDR, 32'h1); // reserved bits written as zero
      rd(SZ_WORD, 32'h0, 32'hccbb_aa11);
      rd(SZ_WORD, REMAP_ADDR, 32'h1);
      access(1'b0, SZ_WORD, 32'h1800, 32'h0, 1'b1, 32'h0);
      wr(SZ_WORD, REMAP_ADDR, 32'h0);
      rd(SZ_WORD, 32'h0, pat(FLASH_BASE));
      wr(SZ_WORD, REMAP_ADDR, 32'h1);
      wr(SZ_WORD, STATUS_ADDR, 32'h4);
      cmp_bit("sys_reset", 1'b1, sys_reset_q);
      cmp_bit("remap", 1'b0, remap_sram_q);
      rst_wait();
      cmp_bit("boot_mode", 1'b1, boot_mode_q);
      rd(SZ_WORD, STATUS_ADDR, 32'h5);
      rd(SZ_WORD, SRAM_BASE, 32'hccbb_aa11);
      wr(SZ_WORD, CLEAR_ADDR, 32'h1);
      cmp_bit("sys_reset", 1'b1, sys_reset_q);
      rst_wait();
      rd(SZ_WORD, STATUS_ADDR, 32'h4);
      wr(SZ_WORD, CLEAR_ADDR, 32'hff);
      cmp_bit("sys_reset", 1'b0, sys_reset_q);
      rd(SZ_WORD, STATUS_ADDR, 32'h0);
      rd(SZ_WORD, CLEAR_ADDR, 32'h0);
      // enable low freezes everything: a watchdog pulse then leaves no trace
      @(posedge clock) clk_en <= 1'b0;
      @(posedge clock) wdog_expire <= 1'b1;
      @(posedge clock) wdog_expire <= 1'b0;
      @(posedge clock) clk_en <= 1'b1;
      @(negedge clock) cmp_bit("sys_reset", 1'b0, sys_reset_q);
      rd(SZ_WORD, STATUS_ADDR, 32'h0);
      @(posedge clock) wdog_expire <= 1'b1;
      @(posedge clock) wdog_expire <= 1'b0;
      @(negedge clock) cmp_bit("sys_reset", 1'b1, sys_reset_q);
      rst_wait();
      rd(SZ_WORD, STATUS_ADDR, 32'h2);
      @(posedge clock) ext_rst_pin_n <= 1'b0;
      repeat (4) @(posedge clock);
      ext_rst_pin_n <= 1'b1;
      @(negedge clock) cmp_bit("sys_reset", 1'b1, sys_reset_q);
      rst_wait();
      rd(SZ_WORD, STATUS_ADDR, 32'ha);
      // random words across the whole array
      for (k = 0; k < 8; k++) begin
         a = SRAM_BASE + 32'(({$random(seed)} % SRAM_WORDS) * 4);
         d = $random(seed);
         wr(SZ_WORD, a, d);
         wr(SZ_BYTE, a + 32'h2, 32'h0000_005e);
         rd(SZ_WORD, a, {d[31:24], 8'h5e, d[15:0]});
      end
      // second power-on in mid-run
      wr(SZ_WORD, REMAP_ADDR, 32'h1);
      @(posedge clock) rst_n <= 1'b0;
      @(posedge clock) rst_n <= 1'b1;
      @(negedge clock) cmp_bit("remap", 1'b0, remap_sram_q);
      rd(SZ_WORD, STATUS_ADDR, 32'h1);
      print_verdict();
   end
endmodule
